// file: dmem_banked_addr.sv
// Banked data-memory addressing: direct and indirect decode, pointers, bank select, accumulator.
// Assumes one access per cycle from the execution core on the same clock; other SFRs live outside.
//
// What this block does
// - Every data memory location is one byte wide.
// - General-purpose bytes are read/write; protected SFRs are left to their owners.
// - Two banks; SFRs in both; EEPROM control at 40H only in bank 1.
// - Data memory addresses start at 00H.
// - Bank 0 RAM at 40H-5FH or 40H-7FH; bank 1 holds only 40H.
// - SFRs decoded at 00H-1FH and 27H-33H; unused ones read zero.
// - Indirect port accesses go to the pointer's address; port stores nothing.
// - First pair reaches bank 0 only; second pair follows the bank bit.
// - An indirect port reached indirectly reads 00H and ignores writes.
// - Both pointers are real 8-bit read/write registers.
// - Direct accesses always go to bank 0.
// - Bank register bit 0 selects the bank; bits 7-1 read zero.
// - Reset clears the bank bit, except watchdog reset in power-down.
// - SFR decode ignores the bank bit, except for EEPROM control at 40H.
// - ALU results land in the accumulator; moves pass through it.
`timescale 1ns/1ps
`include "dmem_defines.svh"

module dmem_banked_addr #(
	parameter int GprBytes = `DMEM_GPR_BYTES_LARGE
) (
	// Clock, reset, enable
	input  wire logic                clock,
	input  wire logic                rst_b,
	input  wire logic                ce,
	input  wire logic                wdtPdWake,
	// Access from the execution core
	input  wire dmem_pkg::dmem_req_t req,
	output logic                     rdValid,
	output logic [7:0]               rdData,
	// ALU result port
	input  wire dmem_pkg::dmem_alu_t alu,
	output logic [7:0]               accValue,
	// Other special-function registers
	output dmem_pkg::dmem_ext_t      ext,
	input  wire logic [7:0]          extRdata,
	// Pointer and bank state for the core
	output logic [7:0]               ptr0Value,
	output logic [7:0]               ptr1Value,
	output logic                     bankSel
);
	import dmem_pkg::*;

	dmem_state_t stQ;
	dmem_state_t stD;

	logic                        access;
	logic                        viaPort0;
	logic                        viaPort1;
	logic                        viaPort;
	logic [7:0]                  effAddr;
	logic                        effBank1;
	logic                        portAgain;
	logic                        ramHit;
	logic                        eecHit;
	logic                        sfrExtHit;
	logic                        ptr0We;
	logic                        ptr1We;
	logic                        ramWe;
	logic [7:0]                  ramRdata;
	logic [`DMEM_GPR_IDX_W-1:0]  ramIdx;

	// Low special-function window minus its holes, plus the high window; never depends on the bank
	function automatic logic isExtSfr(input logic [7:0] a);
		logic lo;
		logic hole;
		lo   = (a >= `DMEM_SFR_LO_START) && (a <= `DMEM_SFR_LO_END);
		hole = (a == `DMEM_SFR_HOLE_A) || (a == `DMEM_SFR_HOLE_B) ||
		       (a == `DMEM_SFR_HOLE_C) || (a == `DMEM_SFR_HOLE_D);
		return (lo && !hole) ||
		       ((a >= `DMEM_SFR_HI_START) && (a <= `DMEM_SFR_HI_END));
	endfunction

	// Address resolution: a port access uses its pointer instead of the address
	assign access    = req.rd || req.we;
	assign viaPort0  = req.addr == `DMEM_ADDR_PORT0;
	assign viaPort1  = req.addr == `DMEM_ADDR_PORT1;
	assign viaPort   = viaPort0 || viaPort1;
	assign effAddr   = viaPort0 ? ptr0Value : (viaPort1 ? ptr1Value : req.addr);
	assign effBank1  = viaPort1 && stQ.bank;
	assign portAgain = viaPort && ((effAddr == `DMEM_ADDR_PORT0) ||
	                              (effAddr == `DMEM_ADDR_PORT1));

	// Region decode; only the GPR and EEPROM control look at the bank
	assign ramHit    = !effBank1 && (effAddr >= `DMEM_GPR_START) &&
	                   (effAddr < (`DMEM_GPR_START + 8'(GprBytes)));
	assign eecHit    = effBank1 && (effAddr == `DMEM_EEC_ADDR);
	assign sfrExtHit = isExtSfr(effAddr) || eecHit;
	assign ramIdx    = effAddr[`DMEM_GPR_IDX_W-1:0];

	// Write strobes; ports themselves never hold data
	assign ptr0We = req.we && effAddr == `DMEM_ADDR_PTR0 && !portAgain;
	assign ptr1We = req.we && effAddr == `DMEM_ADDR_PTR1 && !portAgain;
	assign ramWe  = req.we && ramHit;

	// Forwarded SFR access; protection of those bits stays with their owner
	always_comb begin
		ext.sel   = access && sfrExtHit;
		ext.we    = req.we && sfrExtHit;
		ext.bank1 = eecHit;
		ext.addr  = effAddr;
		ext.wdata = req.wdata;
	end

	dmem_ptr_reg uPtr0 (
		.clock (clock),
		.rst_b (rst_b),
		.ce    (ce),
		.we    (ptr0We),
		.wdata (req.wdata),
		.value (ptr0Value)
	);

	dmem_ptr_reg uPtr1 (
		.clock (clock),
		.rst_b (rst_b),
		.ce    (ce),
		.we    (ptr1We),
		.wdata (req.wdata),
		.value (ptr1Value)
	);

	dmem_gpr_ram #(
		.Bytes (GprBytes)
	) uRam (
		.clock (clock),
		.ce    (ce),
		.we    (ramWe),
		.idx   (ramIdx),
		.wdata (req.wdata),
		.rdata (ramRdata)
	);

	// Next state: bank, accumulator and registered read data
	always_comb begin
		stD         = stQ;
		stD.rdValid = req.rd;
		stD.rdData  = `DMEM_ZERO_BYTE;
		if (req.rd && !portAgain) begin
			if (ramHit) begin
				stD.rdData = ramRdata;
			end else if (sfrExtHit) begin
				stD.rdData = extRdata;
			end else begin
				unique case (effAddr)
					`DMEM_ADDR_PTR0: stD.rdData = ptr0Value;
					`DMEM_ADDR_PTR1: stD.rdData = ptr1Value;
					`DMEM_ADDR_BANK: stD.rdData = {7'h00, stQ.bank};
					`DMEM_ADDR_ACC:  stD.rdData = stQ.acc;
					default:         stD.rdData = `DMEM_ZERO_BYTE;
				endcase
			end
		end
		if (req.we && !portAgain && effAddr == `DMEM_ADDR_BANK) begin
			stD.bank = req.wdata[`DMEM_BANK_BIT];
		end
		// ALU wins over a register write in the same cycle
		if (alu.we) begin
			stD.acc = alu.data;
		end else if (req.we && !portAgain && effAddr == `DMEM_ADDR_ACC) begin
			stD.acc = req.wdata;
		end
		// Watchdog wake from power-down keeps the bank so the program resumes in place
		if (!rst_b) begin
			stD.rdValid = 1'b0;
			stD.rdData  = `DMEM_ZERO_BYTE;
			stD.acc     = `DMEM_ACC_RESET;
			stD.bank    = wdtPdWake ? stQ.bank : `DMEM_BANK_RESET;
		end
	end

	// All state frozen while the clock enable is low
	always_ff @(posedge clock) begin
		if (ce) begin
			stQ <= stD;
		end
	end

	assign rdValid  = stQ.rdValid;
	assign rdData   = stQ.rdData;
	assign accValue = stQ.acc;
	assign bankSel  = stQ.bank;

	// Write of one GPR byte, an idle cycle, then a read of the same byte
	sequence s_gprWrite;
		ce && ramWe;
	endsequence

	sequence s_gprIdle;
		ce && !req.rd && !req.we;
	endsequence

	sequence s_gprRead;
		ce && req.rd && ramHit && ramIdx == $past(ramIdx, 2);
	endsequence

	property p_gprReadBack;
		@(posedge clock) disable iff (!rst_b)
		s_gprWrite ##1 s_gprIdle ##1 s_gprRead |=> (rdData == $past(req.wdata, 3));
	endproperty
	a_gprReadBack: assert property (p_gprReadBack)
		else $error("GPR read-back mismatch");

	property p_unusedSfrZero;
		@(posedge clock) disable iff (!rst_b)
		(ce && req.rd && !viaPort && req.addr >= 8'h20 && req.addr <= 8'h26) |=>
		(rdValid && rdData == 8'h00);
	endproperty
	a_unusedSfrZero: assert property (p_unusedSfrZero)
		else $error("Unused SFR not zero");

	// A port reached through a pointer that holds a port address
	sequence s_portLoopRead;
		ce && req.rd &&
		((viaPort0 && (ptr0Value == 8'h00 || ptr0Value == 8'h02)) ||
		 (viaPort1 && (ptr1Value == 8'h00 || ptr1Value == 8'h02)));
	endsequence

	sequence s_portLoopWrite;
		ce && req.we &&
		((viaPort0 && (ptr0Value == 8'h00 || ptr0Value == 8'h02)) ||
		 (viaPort1 && (ptr1Value == 8'h00 || ptr1Value == 8'h02)));
	endsequence

	property p_portAgainZero;
		@(posedge clock) disable iff (!rst_b)
		s_portLoopRead |=> (rdValid && rdData == 8'h00);
	endproperty
	a_portAgainZero: assert property (p_portAgainZero)
		else $error("Port via port not zero");

	property p_portAgainNop;
		@(posedge clock) disable iff (!rst_b)
		s_portLoopWrite |-> (!ramWe && !ptr0We && !ptr1We && !ext.we);
	endproperty
	a_portAgainNop: assert property (p_portAgainNop)
		else $error("Port via port wrote something");

	// Bank bit: read-back, reset and watchdog wake
	property p_bankHighZero;
		@(posedge clock) disable iff (!rst_b)
		(ce && req.rd && req.addr == 8'h04) |=> (rdData[7:1] == 7'h00 && rdData[0] == bankSel);
	endproperty
	a_bankHighZero: assert property (p_bankHighZero)
		else $error("Bank read wrong");

	property p_bankReset;
		@(posedge clock) (ce && !rst_b && !wdtPdWake) |=> !bankSel;
	endproperty
	a_bankReset: assert property (p_bankReset)
		else $error("Bank not cleared by reset");

	property p_bankKeep;
		@(posedge clock) (ce && !rst_b && wdtPdWake) |=> $stable(bankSel);
	endproperty
	a_bankKeep: assert property (p_bankKeep)
		else $error("Bank lost on watchdog wake");

	// Bank routing of direct and indirect accesses
	property p_directBank0;
		@(posedge clock) disable iff (!rst_b)
		(access && !viaPort && req.addr == 8'h40 && bankSel) |-> (!ext.sel && ramHit);
	endproperty
	a_directBank0: assert property (p_directBank0)
		else $error("Direct access left bank 0");

	property p_port0Bank0;
		@(posedge clock) disable iff (!rst_b)
		(access && viaPort0 && bankSel && ptr0Value >= 8'h40 && ptr0Value <= 8'h5f) |->
		(!ext.sel && ramHit);
	endproperty
	a_port0Bank0: assert property (p_port0Bank0)
		else $error("Port 0 left bank 0");

	property p_port1Eec;
		@(posedge clock) disable iff (!rst_b)
		(req.we && viaPort1 && ptr1Value == 8'h40 && bankSel) |-> (ext.sel && ext.bank1 && !ramWe);
	endproperty
	a_port1Eec: assert property (p_port1Eec)
		else $error("EEPROM control not reached");

	property p_sfrAnyBank;
		@(posedge clock) disable iff (!rst_b)
		(access && viaPort1 && bankSel && ptr1Value >= 8'h27 && ptr1Value <= 8'h33) |->
		(ext.sel && !ext.bank1 && ext.addr == ptr1Value);
	endproperty
	a_sfrAnyBank: assert property (p_sfrAnyBank)
		else $error("SFR decode followed the bank");

	property p_unimplNop;
		@(posedge clock) disable iff (!rst_b)
		(ce && req.we && ((!viaPort && req.addr[7]) ||
		 (viaPort1 && bankSel && ptr1Value >= 8'h41))) |-> (!ramWe && !ext.sel);
	endproperty
	a_unimplNop: assert property (p_unimplNop)
		else $error("Write to an empty address landed");

	// Accumulator and pointer writes
	property p_accAlu;
		@(posedge clock) disable iff (!rst_b)
		(ce && alu.we) |=> (accValue == $past(alu.data));
	endproperty
	a_accAlu: assert property (p_accAlu)
		else $error("Accumulator missed ALU result");

	property p_ptrWrite;
		@(posedge clock) disable iff (!rst_b)
		(ce && req.we && req.addr == 8'h01) |=> (ptr0Value == $past(req.wdata));
	endproperty
	a_ptrWrite: assert property (p_ptrWrite)
		else $error("Pointer 0 write lost");
endmodule

// file: dmem_defines.svh
// Address map, field positions, reset values and size limits of the data-memory addressing block.
// Assumes an 8-bit data path and an 8-bit data-memory address from the execution core.
`ifndef DMEM_DEFINES_SVH
`define DMEM_DEFINES_SVH

// Register offsets, identical in both banks
`define DMEM_ADDR_PORT0      8'h00
`define DMEM_ADDR_PTR0       8'h01
`define DMEM_ADDR_PORT1      8'h02
`define DMEM_ADDR_PTR1       8'h03
`define DMEM_ADDR_BANK       8'h04
`define DMEM_ADDR_ACC        8'h05

// Special-function windows handled by the rest of the core
`define DMEM_SFR_LO_START    8'h06
`define DMEM_SFR_LO_END      8'h1f
`define DMEM_SFR_HI_START    8'h27
`define DMEM_SFR_HI_END      8'h33

// Holes inside the low special-function window
`define DMEM_SFR_HOLE_A      8'h0c
`define DMEM_SFR_HOLE_B      8'h10
`define DMEM_SFR_HOLE_C      8'h13
`define DMEM_SFR_HOLE_D      8'h1d

// General-purpose area and the bank 1 EEPROM control register
`define DMEM_GPR_START       8'h40
`define DMEM_EEC_ADDR        8'h40
`define DMEM_GPR_BYTES_SMALL 32
`define DMEM_GPR_BYTES_LARGE 64
`define DMEM_GPR_IDX_W       6

// Bank select field and reset values
`define DMEM_BANK_BIT        0
`define DMEM_BANK_RESET      1'b0
`define DMEM_PTR_RESET       8'h00
`define DMEM_ACC_RESET       8'h00
`define DMEM_ZERO_BYTE       8'h00

`endif

// file: dmem_gpr_ram.sv
// General-purpose RAM of bank 0, one byte per location.
// Assumes the caller only strobes writes for in-range indices; contents are volatile.
`timescale 1ns/1ps
`include "dmem_defines.svh"

module dmem_gpr_ram #(
	parameter int Bytes = `DMEM_GPR_BYTES_LARGE
) (
	// Clock and enable
	input  wire logic                        clock,
	input  wire logic                        ce,
	// Access port
	input  wire logic                        we,
	input  wire logic [`DMEM_GPR_IDX_W-1:0]  idx,
	input  wire logic [7:0]                  wdata,
	output logic      [7:0]                  rdata
);
	import dmem_pkg::*;

	typedef struct packed {
		logic [Bytes-1:0][7:0] mem;
	} dmem_ram_state_t;

	dmem_ram_state_t stQ;
	dmem_ram_state_t stD;

	// No reset: RAM holds nothing defined after power-up
	always_comb begin
		stD = stQ;
		if (we) begin
			stD.mem[idx] = wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (ce) begin
			stQ <= stD;
		end
	end

	// Read is combinational; the caller registers it
	assign rdata = stQ.mem[idx];
endmodule

// file: dmem_pkg.sv
// Types shared by the data-memory addressing block.
// Assumes dmem_defines.svh is on the include path.
package dmem_pkg;

	// One data-memory access from the execution core
	typedef struct packed {
		logic       rd;
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dmem_req_t;

	// Access forwarded to special-function registers kept elsewhere in the core
	typedef struct packed {
		logic       sel;
		logic       we;
		logic       bank1;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dmem_ext_t;

	// Result written by the ALU
	typedef struct packed {
		logic       we;
		logic [7:0] data;
	} dmem_alu_t;

	// State of the top block
	typedef struct packed {
		logic       bank;
		logic [7:0] acc;
		logic [7:0] rdData;
		logic       rdValid;
	} dmem_state_t;

	// State of one memory pointer
	typedef struct packed {
		logic [7:0] value;
	} dmem_ptr_state_t;

endpackage

// file: dmem_ptr_reg.sv
// One 8-bit memory pointer, a plain read/write register.
// Assumes the caller decodes the write strobe; increments and decrements arrive as writes.
`timescale 1ns/1ps
`include "dmem_defines.svh"

module dmem_ptr_reg (
	// Clock, reset, enable
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       ce,
	// Write port
	input  wire logic       we,
	input  wire logic [7:0] wdata,
	// Current value
	output logic      [7:0] value
);
	import dmem_pkg::*;

	dmem_ptr_state_t stQ;
	dmem_ptr_state_t stD;

	// Next value: reset, then write
	always_comb begin
		stD = stQ;
		if (!rst_b) begin
			stD.value = `DMEM_PTR_RESET;
		end else if (we) begin
			stD.value = wdata;
		end
	end

	// Frozen while the clock enable is low
	always_ff @(posedge clock) begin
		if (ce) begin
			stQ <= stD;
		end
	end

	assign value = stQ.value;
endmodule

// file: dmem_sfr_model.sv
// Far-side model of the special-function registers kept outside the block, EEPROM control too.
// Assumes a combinational ext request and read data sampled in the same cycle.
`timescale 1ns/1ps

module dmem_sfr_model (
	// Clock
	input  wire logic                clock,
	// Forwarded access
	input  wire dmem_pkg::dmem_ext_t ext,
	output logic [7:0]               extRdata
);
	import dmem_pkg::*;

	logic [7:0] store [0:511];
	logic [7:0] noise = 8'ha5;

	// Store writes per bank slot so a wrongly banked access shows up
	always @(posedge clock) begin
		noise <= ~noise;
		if (ext.sel && ext.we) begin
			store[{ext.bank1, ext.addr}] <= ext.wdata;
		end
	end

	// Unselected bus changes every cycle so a stale value never passes
	assign extRdata = ext.sel ? store[{ext.bank1, ext.addr}] : noise;
endmodule

// file: tb_top.sv
// Self-checking bench for the banked data-memory addressing block.
// Assumes the outside registers are modelled by dmem_sfr_model.
`timescale 1ns/1ps

module tb_top;
	import dmem_pkg::*;

	logic        clock, rst_b, ce, wdtPdWake, rdValid, bankSel, gotValid;
	dmem_req_t   req;
	dmem_alu_t   alu;
	dmem_ext_t   ext;
	logic [7:0]  rdData, accValue, extRdata, ptr0Value, ptr1Value, gotData;
	int          fails, num_checks, cycles;

	dmem_banked_addr #(.GprBytes(64)) dut (.clock(clock), .rst_b(rst_b), .ce(ce),
		.wdtPdWake(wdtPdWake), .req(req), .rdValid(rdValid), .rdData(rdData), .alu(alu),
		.accValue(accValue), .ext(ext), .extRdata(extRdata), .ptr0Value(ptr0Value),
		.ptr1Value(ptr1Value), .bankSel(bankSel));
	dmem_sfr_model sfr (.clock(clock), .ext(ext), .extRdata(extRdata));

	// Clock and hang guard
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			end_of_test();
		end
	end

	task end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One access, then an idle cycle so no strobe is driven twice in one step
	task xfer(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
		req = '{rd: r, we: w, addr: a, wdata: d};
		@(posedge clock); #1;
		gotValid = rdValid;
		gotData = rdData;
		req = '0;
		@(posedge clock); #1;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b0, 1'b1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b1, 1'b0, a, 8'h00);
		chk({7'h00, gotValid}, 8'h01);
		chk(gotData, e);
	endtask

	task do_reset(input logic wake);
		rst_b = 1'b0;
		wdtPdWake = wake;
		@(posedge clock); #1;
		rst_b = 1'b1;
		wdtPdWake = 1'b0;
		@(posedge clock); #1;
	endtask

	task t_reset_vals();
		rd(8'h01, 8'h00);
		rd(8'h04, 8'h00);
		chk({7'h00, bankSel}, 8'h00);
	endtask

	task t_direct();
		wr(8'h40, 8'h11);
		wr(8'h7f, 8'he7);
		rd(8'h40, 8'h11);
		rd(8'h7f, 8'he7);
		wr(8'h80, 8'h33);
		rd(8'h80, 8'h00);
	endtask

	task t_pointers();
		wr(8'h01, 8'h45);
		wr(8'h03, 8'hfe);
		rd(8'h03, 8'hfe);
		chk(ptr0Value, 8'h45);
		wr(8'h00, 8'h9c);
		rd(8'h45, 8'h9c);
		rd(8'h00, 8'h9c);
	endtask

	task t_banks();
		wr(8'h04, 8'hff);
		rd(8'h04, 8'h01);
		wr(8'h41, 8'h5a);
		wr(8'h01, 8'h41);
		rd(8'h00, 8'h5a);
		wr(8'h03, 8'h40);
		chk(ptr1Value, 8'h40);
		wr(8'h02, 8'h3c);
		rd(8'h02, 8'h3c);
		rd(8'h40, 8'h11);
		wr(8'h03, 8'h41);
		wr(8'h02, 8'h77);
		rd(8'h02, 8'h00);
		wr(8'h03, 8'h00);
		rd(8'h02, 8'h00);
		wr(8'h02, 8'h66);
		rd(8'h41, 8'h5a);
	endtask

	task t_sfr();
		wr(8'h07, 8'hc3);
		wr(8'h04, 8'h00);
		rd(8'h07, 8'hc3);
		rd(8'h0c, 8'h00);
		rd(8'h25, 8'h00);
		rd(8'h34, 8'h00);
		wr(8'h03, 8'h30);
		wr(8'h02, 8'h5e);
		wr(8'h04, 8'h01);
		rd(8'h02, 8'h5e);
	endtask

	// Clock enable low: neither the RAM nor the bank bit may move
	task t_freeze();
		ce = 1'b0;
		wr(8'h40, 8'hee);
		wr(8'h04, 8'h00);
		ce = 1'b1;
		chk({7'h00, bankSel}, 8'h01);
		rd(8'h40, 8'h11);
	endtask

	// ALU result and a register write to the accumulator in one cycle; ALU for one cycle only
	task t_acc();
		alu = '{we: 1'b1, data: 8'h24};
		req = '{rd: 1'b0, we: 1'b1, addr: 8'h05, wdata: 8'h99};
		@(posedge clock); #1;
		alu = '0;
		req = '0;
		chk(accValue, 8'h24);
		@(posedge clock); #1;
		rd(8'h05, 8'h24);
		wr(8'h05, 8'h3e);
		rd(8'h05, 8'h3e);
	endtask

	task t_wdt();
		wr(8'h04, 8'h01);
		do_reset(1'b1);
		chk({7'h00, bankSel}, 8'h01);
		do_reset(1'b0);
		rd(8'h04, 8'h00);
	endtask

	// Main sequence
	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		wdtPdWake = 1'b0;
		req = '0;
		alu = '0;
		repeat (12) @(posedge clock);
		#1;
		rst_b = 1'b1;
		@(posedge clock); #1;
		t_reset_vals();
		t_direct();
		t_pointers();
		t_banks();
		t_sfr();
		t_freeze();
		t_acc();
		t_wdt();
		end_of_test();
	end
endmodule
